// File: common/prom_consts.vh
// constants for the program store, vector and table-read block
// assumes inclusion by bare name from the design files
`ifndef PROM_CONSTS_VH
`define PROM_CONSTS_VH

// ----------------------------------------
// program store geometry
// ----------------------------------------
`define PROM_ADDR_W 12
`define PROM_WORD_W 15
`define PROM_DEPTH 4096
`define PROM_STACK_LEVELS 4'h8

// ----------------------------------------
// fixed program counter targets and the last table page
// ----------------------------------------
`define PROM_VEC_RESET 12'h000
`define PROM_VEC_USB 12'h004
`define PROM_VEC_CTR0 12'h008
`define PROM_VEC_CTR1 12'h00C
`define PROM_LAST_PAGE 4'hF

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define PROM_IDX_TBL_PTR_LOW 8'h07
`define PROM_IDX_TBL_HIGH_BYTE 8'h08
`define PROM_IDX_TBL_PTR_HIGH 8'h1F
`define PROM_IDX_CONFIG 8'h30
`define PROM_IDX_STATUS 8'h31
`define PROM_IDX_LOAD_ADDR 8'h32
`define PROM_IDX_LOAD_DATA 8'h33

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PROM_CFG_HIGH_PTR_EN_BIT 0
`define PROM_RST_TBL_PTR 8'h00
`define PROM_RST_TBL_HIGH 8'h00
`define PROM_RST_CONFIG 1'h0

// ----------------------------------------
// bus answers
// ----------------------------------------
`define PROM_RESP_OKAY 2'h0
`define PROM_RESP_SLVERR 2'h2

`endif

// File: verilog/program_store.v
// 4096 x 15 program store, one read port and one load port
// assumes both ports on the same clock; read data is registered
`timescale 1ns/1ps
`include "prom_consts.vh"

module program_store (
  // clock
  input wire aclk,
  // load port
  input wire wr_en,
  input wire [11:0] wr_addr,
  input wire [14:0] wr_data,
  // read port
  input wire [11:0] rd_addr,
  output reg [14:0] rd_data
);

  reg [14:0] mem [0:`PROM_DEPTH-1];

  // contents are not reset; a fresh store reads unknown until loaded
  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // program_store

// File: verilog/program_rom_vectors_table_read.v
// program counter, return stack, vectors and table reads over a 4K x 15 store
// assumes the cpu core drives control pulses on aclk, one instruction cycle per edge;
// software reaches the table registers and the store loader over AXI4-Lite
//
// Summary of operation
// - store holds 4096 words of 15 bits, addressed by the 12-bit pc
// - any reset loads the pc with 000H
// - enabled usb request with stack room branches to 004H
// - enabled counter 0 overflow with stack room branches to 008H
// - enabled counter 1 overflow with stack room branches to 00CH
// - high pointer disabled: current-page read uses pc bits 11..8 and low pointer
// - high pointer enabled: current-page read takes address bits 11..8 from high pointer bits 3..0
// - last-page read forces address bits 11..8 to all ones
// - low byte goes to named data register, upper bits to table-high register
// - table-high register is read only; writes leave it unchanged
// - low and high table pointers are readable and writable
// - disabled high pointer has no effect on any table address
// - a table read takes two instruction cycles
// - table-high register sits at data address 08H
// - with a full eight-level stack, requests stay latched until a return
// - interrupt acknowledge pushes the pc before loading the vector
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "prom_consts.vh"

module program_rom_vectors_table_read (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // program flow control from the core
  input wire jump_req,
  input wire call_req,
  input wire [11:0] branch_target,
  input wire return_req,
  // table read requests from the core
  input wire table_read_current_page,
  input wire table_read_last_page,
  input wire [7:0] table_dest_addr,
  // interrupt sources and enables
  input wire usb_irq,
  input wire usb_irq_en,
  input wire ctr0_overflow,
  input wire ctr0_irq_en,
  input wire ctr1_overflow,
  input wire ctr1_irq_en,
  // fetch result to the core
  output reg [14:0] instr_word,
  output reg [11:0] instr_addr,
  output reg instr_valid,
  output reg [11:0] program_counter,
  // table result to the data memory
  output reg table_write,
  output reg [7:0] table_write_addr,
  output reg [7:0] table_write_data,
  // interrupt acknowledge to the core
  output reg irq_ack,
  output reg [11:0] irq_vector
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // merge one byte lane of a write into an old byte
  function [7:0] lane_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input strobe;
    begin
      lane_merge = strobe ? new_val : old_val;
    end
  endfunction

  // bus byte address to register index
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [11:0] stack [0:7];
  reg [3:0] sp_count;
  reg [7:0] table_pointer_low;
  reg [7:0] table_pointer_high;
  reg [7:0] table_high_byte;
  reg high_ptr_enable;
  reg [11:0] load_addr;
  reg tbl_access;
  reg tbl_capture;
  reg fetch_pending;
  reg [11:0] fetch_addr;
  reg [11:0] tbl_addr;
  reg [7:0] tbl_dest;
  reg pend_usb;
  reg pend_ctr0;
  reg pend_ctr1;

  wire [14:0] store_rd_data;
  wire [11:0] store_rd_addr;
  wire stack_full;
  wire table_req;
  wire [3:0] page_bits;
  wire [11:0] next_table_addr;
  wire [11:0] pc_plus_one;
  wire flow_busy;
  wire ack_usb;
  wire ack_ctr0;
  wire ack_ctr1;
  wire any_ack;
  wire [11:0] ack_vector;

  // ----------------------------------------
  // program store
  // ----------------------------------------
  wire wr_fire;
  wire [7:0] wr_idx;
  wire store_load;

  assign store_rd_addr = tbl_access ? tbl_addr : program_counter;

  program_store u_store (
    .aclk(aclk),
    .wr_en(store_load),
    .wr_addr(load_addr),
    .wr_data(s_axi_wdata[14:0]),
    .rd_addr(store_rd_addr),
    .rd_data(store_rd_data)
  );

  // ----------------------------------------
  // table address formation
  // ----------------------------------------
  // a disabled high pointer is never looked at, whatever it holds
  assign page_bits = table_read_last_page ? `PROM_LAST_PAGE :
                     (high_ptr_enable ? table_pointer_high[3:0] :
                      program_counter[11:8]);
  assign next_table_addr = {page_bits, table_pointer_low};
  assign table_req = table_read_current_page | table_read_last_page;

  // ----------------------------------------
  // interrupt arbitration
  // ----------------------------------------
  assign stack_full = (sp_count == `PROM_STACK_LEVELS);
  // a control request of the core owns this cycle; acknowledge waits
  assign flow_busy = tbl_access | table_req | return_req | call_req | jump_req;
  assign ack_usb = pend_usb & usb_irq_en & ~stack_full & ~flow_busy;
  assign ack_ctr0 = pend_ctr0 & ctr0_irq_en & ~stack_full & ~flow_busy & ~ack_usb;
  assign ack_ctr1 = pend_ctr1 & ctr1_irq_en & ~stack_full & ~flow_busy & ~ack_usb & ~ack_ctr0;
  assign any_ack = ack_usb | ack_ctr0 | ack_ctr1;
  assign ack_vector = ack_usb ? `PROM_VEC_USB : (ack_ctr0 ? `PROM_VEC_CTR0 : `PROM_VEC_CTR1);
  assign pc_plus_one = program_counter + 12'h001;

  // ----------------------------------------
  // program counter, stack and table sequence
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      program_counter <= `PROM_VEC_RESET;
      sp_count <= 4'h0;
      tbl_access <= 1'b0;
      tbl_capture <= 1'b0;
      fetch_pending <= 1'b0;
      fetch_addr <= 12'h000;
      tbl_addr <= 12'h000;
      tbl_dest <= 8'h00;
      irq_ack <= 1'b0;
      irq_vector <= 12'h000;
    end else begin
      irq_ack <= 1'b0;
      tbl_capture <= tbl_access;
      fetch_pending <= ~tbl_access;
      fetch_addr <= program_counter;
      if (tbl_access) begin
        // second cycle: store busy with the table word, pc holds
        tbl_access <= 1'b0;
      end else if (table_req) begin
        tbl_access <= 1'b1;
        tbl_addr <= next_table_addr;
        tbl_dest <= table_dest_addr;
        program_counter <= pc_plus_one;
      end else if (return_req) begin
        // an empty stack pops nothing and the pc just advances
        if (sp_count != 4'h0) begin
          program_counter <= stack[sp_count[2:0] - 3'h1];
          sp_count <= sp_count - 4'h1;
        end else begin
          program_counter <= pc_plus_one;
        end
      end else if (call_req) begin
        // a call on a full stack overwrites the top level, as the core expects
        stack[stack_full ? 3'h7 : sp_count[2:0]] <= pc_plus_one;
        if (!stack_full) begin
          sp_count <= sp_count + 4'h1;
        end
        program_counter <= branch_target;
      end else if (jump_req) begin
        program_counter <= branch_target;
      end else if (any_ack) begin
        stack[sp_count[2:0]] <= program_counter;
        sp_count <= sp_count + 4'h1;
        program_counter <= ack_vector;
        irq_ack <= 1'b1;
        irq_vector <= ack_vector;
      end else begin
        program_counter <= pc_plus_one;
      end
    end
  end

  // ----------------------------------------
  // interrupt request latches
  // ----------------------------------------
  // a new request in the acknowledge cycle wins over the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_usb <= 1'b0;
      pend_ctr0 <= 1'b0;
      pend_ctr1 <= 1'b0;
    end else begin
      pend_usb <= usb_irq | (pend_usb & ~ack_usb);
      pend_ctr0 <= ctr0_overflow | (pend_ctr0 & ~ack_ctr0);
      pend_ctr1 <= ctr1_overflow | (pend_ctr1 & ~ack_ctr1);
    end
  end

  // ----------------------------------------
  // fetch and table results
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      instr_word <= 15'h0000;
      instr_addr <= 12'h000;
      instr_valid <= 1'b0;
      table_write <= 1'b0;
      table_write_addr <= 8'h00;
      table_write_data <= 8'h00;
      table_high_byte <= `PROM_RST_TBL_HIGH;
    end else begin
      instr_valid <= fetch_pending & ~tbl_capture;
      table_write <= tbl_capture;
      if (fetch_pending && !tbl_capture) begin
        instr_word <= store_rd_data;
        instr_addr <= fetch_addr;
      end
      if (tbl_capture) begin
        table_write_addr <= tbl_dest;
        table_write_data <= store_rd_data[7:0];
        table_high_byte <= {1'b0, store_rd_data[14:8]};
      end
    end
  end

  // ----------------------------------------
  // axi4-lite write side
  // ----------------------------------------
  // both address and data must be present; the slave waits for the later one
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_fire = s_axi_awready;
  assign wr_idx = reg_index(s_axi_awaddr);
  assign store_load = wr_fire && wr_idx == `PROM_IDX_LOAD_DATA && s_axi_wstrb[1:0] == 2'h3;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PROM_RESP_OKAY;
      table_pointer_low <= `PROM_RST_TBL_PTR;
      table_pointer_high <= `PROM_RST_TBL_PTR;
      high_ptr_enable <= `PROM_RST_CONFIG;
      load_addr <= 12'h000;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PROM_RESP_OKAY;
        case (wr_idx)
          `PROM_IDX_TBL_PTR_LOW: begin
            table_pointer_low <= lane_merge(table_pointer_low, s_axi_wdata[7:0], s_axi_wstrb[0]);
          end
          `PROM_IDX_TBL_PTR_HIGH: begin
            table_pointer_high <= lane_merge(table_pointer_high, s_axi_wdata[7:0], s_axi_wstrb[0]);
          end
          `PROM_IDX_TBL_HIGH_BYTE: begin
            // accepted and dropped: contents only change by a table read
            s_axi_bresp <= `PROM_RESP_OKAY;
          end
          `PROM_IDX_CONFIG: begin
            if (s_axi_wstrb[0]) begin
              high_ptr_enable <= s_axi_wdata[`PROM_CFG_HIGH_PTR_EN_BIT];
            end
          end
          `PROM_IDX_LOAD_ADDR: begin
            if (s_axi_wstrb[1:0] == 2'h3) begin
              load_addr <= s_axi_wdata[11:0];
            end
          end
          `PROM_IDX_LOAD_DATA: begin
            // auto-increment lets a loader stream the whole store
            if (store_load) begin
              load_addr <= load_addr + 12'h001;
            end
          end
          default: begin
            s_axi_bresp <= `PROM_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read side
  // ----------------------------------------
  wire [7:0] rd_idx;
  assign rd_idx = reg_index(s_axi_araddr);
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PROM_RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PROM_RESP_OKAY;
        case (rd_idx)
          `PROM_IDX_TBL_PTR_LOW: begin
            s_axi_rdata <= {24'h000000, table_pointer_low};
          end
          `PROM_IDX_TBL_PTR_HIGH: begin
            s_axi_rdata <= {24'h000000, table_pointer_high};
          end
          `PROM_IDX_TBL_HIGH_BYTE: begin
            s_axi_rdata <= {24'h000000, table_high_byte};
          end
          `PROM_IDX_CONFIG: begin
            s_axi_rdata <= {31'h00000000, high_ptr_enable};
          end
          `PROM_IDX_STATUS: begin
            s_axi_rdata <= {9'h000, pend_ctr1, pend_ctr0, pend_usb, sp_count, 4'h0, program_counter};
          end
          `PROM_IDX_LOAD_ADDR: begin
            s_axi_rdata <= {20'h00000, load_addr};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PROM_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule // program_rom_vectors_table_read

// File: verif/prom_props.sv
// checker for the program store block: table timing, vectors and bus answers
// assumes it is bound to the top module; one clock, synchronous low reset
`timescale 1ns/1ps
module prom_props (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // core side
  input wire table_read_current_page,
  input wire table_read_last_page,
  input wire [7:0] table_dest_addr,
  input wire [11:0] program_counter,
  input wire table_write,
  input wire [7:0] table_write_addr,
  input wire irq_ack,
  input wire [11:0] irq_vector
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire tbl_req = table_read_current_page | table_read_last_page;

  property p_reset_pc;
    $rose(aresetn) |-> program_counter == 12'h000;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset");
  property p_vector;
    irq_ack |-> program_counter == irq_vector && irq_vector inside {12'h004, 12'h008, 12'h00C};
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector on acknowledge");
  property p_tbl_two_cycles;
    table_write |-> $past(tbl_req, 3);
  endproperty
  a_tbl_two_cycles: assert property (p_tbl_two_cycles) else $error("table result at wrong time");
  property p_tbl_dest;
    table_write |-> table_write_addr == $past(table_dest_addr, 3);
  endproperty
  a_tbl_dest: assert property (p_tbl_dest) else $error("table destination wrong");
  property p_fetch_held;
    table_write |-> $past(program_counter, 1) == $past(program_counter, 2);
  endproperty
  a_fetch_held: assert property (p_fetch_held) else $error("fetch not suspended");
  property p_write_answer;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no write response");
  property p_read_answer;
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no read response");
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data dropped");

  c_ctr1: cover property (irq_ack && irq_vector == 12'h00C);
  c_table: cover property (table_write);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // prom_props

// File: verif/core_model.sv
// cpu core stand-in: flow, table and interrupt pulses, one per call
// assumes one instruction per aclk edge; the bench calls op and set_en
`timescale 1ns/1ps
module core_model (
  // clock
  input wire aclk,
  // flow, table and interrupt lines
  output wire jump_req,
  output wire call_req,
  output wire return_req,
  output wire table_read_current_page,
  output wire table_read_last_page,
  output wire usb_irq,
  output wire ctr0_overflow,
  output wire ctr1_overflow,
  output reg [11:0] branch_target = 12'h000,
  output reg [7:0] table_dest_addr = 8'h00,
  // enables
  output wire usb_irq_en,
  output wire ctr0_irq_en,
  output wire ctr1_irq_en
);
  reg [7:0] pulse = 8'h00;
  reg [2:0] en = 3'h0;
  assign {ctr1_overflow, ctr0_overflow, usb_irq, table_read_last_page, table_read_current_page} = pulse[7:3];
  assign {return_req, call_req, jump_req} = pulse[2:0];
  assign {ctr1_irq_en, ctr0_irq_en, usb_irq_en} = en;

  // k: 0 jump, 1 call, 2 return, 3 current page, 4 last page, 5..7 interrupt sources
  task op(input integer k, input [11:0] t);
    begin
      @(posedge aclk);
      pulse <= 8'h01 << k;
      branch_target <= t;
      table_dest_addr <= t[7:0];
      // one-cycle pulse, so table requests are never closer than two cycles
      @(posedge aclk);
      pulse <= 8'h00;
    end
  endtask

  task set_en(input [2:0] e);
    begin
      @(posedge aclk);
      en <= e;
    end
  endtask
endmodule // core_model

// File: verif/program_rom_vectors_table_read_bench.sv
// bench: bus tasks, core model and table, vector and stack scenarios
// assumes the register map of the block; store is loaded over the bus
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
`define WAIT(c) begin n = 0; #1; while (!(c) && n < 60) begin @(posedge aclk); #1; n++; end if (n >= 60) begin $display("[ERR] %0t timeout", $time); fails++; conclude; end end
module program_rom_vectors_table_read_bench;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire jr, cr, rr, tc, tl, ui, c0, c1, ue, c0e, c1e, table_write, irq_ack, instr_valid;
  wire [11:0] bt, program_counter, irq_vector, instr_addr;
  wire [14:0] instr_word;
  wire [7:0] td, table_write_addr, table_write_data;
  int n, i, fails = 0, checks_done = 0;
  reg [31:0] d;
  reg [1:0] r;

  always #12.5 aclk = ~aclk;

  core_model i_core (.aclk(aclk), .jump_req(jr), .call_req(cr), .return_req(rr), .table_read_current_page(tc),
    .table_read_last_page(tl), .usb_irq(ui), .ctr0_overflow(c0), .ctr1_overflow(c1), .branch_target(bt),
    .table_dest_addr(td), .usb_irq_en(ue), .ctr0_irq_en(c0e), .ctr1_irq_en(c1e));

  program_rom_vectors_table_read i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready),
    .jump_req(jr), .call_req(cr), .branch_target(bt), .return_req(rr), .table_read_current_page(tc),
    .table_read_last_page(tl), .table_dest_addr(td), .usb_irq(ui), .usb_irq_en(ue), .ctr0_overflow(c0),
    .ctr0_irq_en(c0e), .ctr1_overflow(c1), .ctr1_irq_en(c1e), .instr_word(instr_word),
    .instr_addr(instr_addr), .instr_valid(instr_valid),
    .program_counter(program_counter), .table_write(table_write), .table_write_addr(table_write_addr),
    .table_write_data(table_write_data), .irq_ack(irq_ack), .irq_vector(irq_vector));

  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  task wr(input [31:0] a, input [31:0] v, input [1:0] e);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      `WAIT(s_axi_awready === 1'b1)
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      `WAIT(s_axi_bvalid === 1'b1)
      `CHK(s_axi_bresp, e)
      @(posedge aclk);
      bready <= 1'b0;
    end
  endtask

  // rready comes late on purpose so the response has to stand
  task rd(input [31:0] a, output [31:0] v, output [1:0] e);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      `WAIT(s_axi_arready === 1'b1)
      @(posedge aclk);
      arvalid <= 1'b0;
      `WAIT(s_axi_rvalid === 1'b1)
      @(posedge aclk);
      rready <= 1'b1;
      `WAIT(s_axi_rvalid === 1'b1)
      v = s_axi_rdata;
      e = s_axi_rresp;
      @(posedge aclk);
      rready <= 1'b0;
    end
  endtask

  task ld(input [11:0] a, input [14:0] w);
    begin
      wr(32'hC8, {20'h0, a}, 2'h0);
      wr(32'hCC, {17'h0, w}, 2'h0);
    end
  endtask

  // current-page reads jump into page 2 first so the page is known
  task tr(input last, input [14:0] w, input [7:0] dst);
    begin
      if (!last) i_core.op(0, 12'h2F0);
      i_core.op(last ? 4 : 3, {4'h0, dst});
      `WAIT(table_write === 1'b1)
      `CHK(table_write_data, w[7:0])
      `CHK(table_write_addr, dst)
      rd(32'h20, d, r);
      `CHK(d, {25'h0, w[14:8]})
    end
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK(program_counter, 12'h000)
    rd(32'h1C, d, r);
    `CHK(d, 32'h0)
    rd(32'h7C, d, r);
    `CHK(d, 32'h0)
    rd(32'h20, d, r);
    `CHK(d, 32'h0)
    wr(32'h1C, 32'hA5, 2'h0);
    wr(32'h7C, 32'hF3, 2'h0);
    rd(32'h7C, d, r);
    `CHK(d, 32'hF3)
    ld(12'h2A5, 15'h3C5A);
    ld(12'h3A5, 15'h7F81);
    ld(12'hF06, 15'h4D1A);
    ld(12'hF05, 15'h000F);
    i_core.op(0, 12'h2A5);
    repeat (2) @(posedge aclk);
    #1;
    `CHK({instr_valid, instr_addr, instr_word}, {1'b1, 12'h2A5, 15'h3C5A})
    tr(1'b0, 15'h3C5A, 8'h40);
    wr(32'hC0, 32'h1, 2'h0);
    tr(1'b0, 15'h7F81, 8'h41);
    wr(32'h1C, 32'h06, 2'h0);
    tr(1'b1, 15'h4D1A, 8'h42);
    wr(32'h1C, 32'h05, 2'h0);
    tr(1'b1, 15'h000F, 8'h43);
    wr(32'h20, 32'hFF, 2'h0);
    rd(32'h20, d, r);
    `CHK(d, 32'h0)
    rd(32'h40, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    wr(32'h40, 32'h1, 2'h2);
    for (i = 0; i < 3; i++) begin
      i_core.set_en(3'h1 << i);
      i_core.op(5 + i, 12'h000);
      `WAIT(irq_ack === 1'b1)
      `CHK(irq_vector, (i + 1) * 4)
      rd(32'hC4, d, r);
      `CHK(d[19:16], i + 1)
    end
    repeat (5) i_core.op(1, 12'h100);
    rd(32'hC4, d, r);
    `CHK(d[19:16], 4'h8)
    i_core.set_en(3'h1);
    i_core.op(5, 12'h000);
    n = 0;
    repeat (10) begin
      @(posedge aclk);
      #1;
      if (irq_ack === 1'b1) n++;
    end
    `CHK(n, 0)
    i_core.op(2, 12'h000);
    `WAIT(irq_ack === 1'b1)
    `CHK(irq_vector, 12'h004)
    conclude;
  end
endmodule // program_rom_vectors_table_read_bench

bind program_rom_vectors_table_read prom_props i_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .table_read_current_page(table_read_current_page),
  .table_read_last_page(table_read_last_page), .table_dest_addr(table_dest_addr),
  .program_counter(program_counter), .table_write(table_write), .table_write_addr(table_write_addr),
  .irq_ack(irq_ack), .irq_vector(irq_vector));
